// ===== core/diag_cfg_pkg.sv
// Package: constants, codes and carriers for the diagnostic/config register bank
// Assumes: serial frame decoder upstream delivers main address, subaddress and strobes
package diag_cfg_pkg;
	// ==========================================================
	// Addresses
	localparam logic [4:0] MAIN_DIAG      = 5'h10;
	localparam logic [4:0] MAIN_ANSWER    = 5'h0E;
	localparam logic [4:0] MAIN_WDCTRL    = 5'h11;
	localparam logic [4:0] MAIN_LAYOUT    = 5'h12;
	localparam logic [7:0] SUB_FIRST      = 8'h01;
	localparam logic [7:0] SUB_LAST       = 8'h07;
	localparam int         NUM_STAGES     = 28;
	// ==========================================================
	// Reset values and bit positions
	localparam logic [7:0] DIAG_RESET     = 8'h00;
	localparam logic [7:0] WDCTRL_RESET   = 8'h00;
	localparam logic       LAYOUT_RESET   = 1'b1;
	localparam logic [7:0] DIAG_CLEAR     = 8'hFF;
	localparam logic [7:0] REG5_ONES      = 8'hF0;
	localparam logic [7:0] REG3_ONES      = 8'h04;
	localparam int         ALARM_BIT      = 3;
	localparam int         WDC_RESET_BIT  = 7;
	localparam int         WDC_CANOFF_BIT = 6;
	localparam int         WDC_WIN_MSB    = 5;
	localparam int         LAYOUT_BIT     = 0;
	// ==========================================================
	// Field codes
	localparam logic [1:0] GF_SCG = 2'h0;
	localparam logic [1:0] GF_OL  = 2'h1;
	localparam logic [1:0] GF_SCB = 2'h2;
	localparam logic [1:0] BF_SCB = 2'h0;
	localparam logic [1:0] BF_OL  = 2'h1;
	localparam logic [1:0] BF_SCG = 2'h2;
	localparam logic [1:0] FLD_OK = 2'h3;
	localparam logic [7:0] HB_SCG_OFF = 8'h01;
	localparam logic [7:0] HB_SCB_OFF = 8'h05;
	localparam logic [7:0] HB_OL_OFF  = 8'h04;
	localparam logic [7:0] HB_OL_ON   = 8'h02;
	localparam logic [7:0] HB_OVC_ON  = 8'h03;
	localparam logic [7:0] HB_RUNNING = 8'h07;
	localparam logic [7:0] HB_OK      = 8'hFF;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {KIND_NONE, KIND_SCG, KIND_OL, KIND_SCB} fault_kind_e;
	typedef enum logic [2:0] {BK_NONE, BK_SCG_OFF, BK_SCB_OFF, BK_OL_OFF, BK_OL_ON, BK_OVC_ON, BK_RUNNING} bridge_kind_e;
	typedef struct packed {
		logic        valid;
		fault_kind_e kind;
	} stage_evt_s;
	typedef struct packed {
		logic         valid;
		bridge_kind_e kind;
	} bridge_evt_s;
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [4:0] main_addr;
		logic [7:0] sub_addr;
		logic [7:0] wdata;
	} reg_req_s;
endpackage : diag_cfg_pkg

// ===== core/driver_diag_config_regs.sv
// Register bank: watchdog answer/control, bridge layout, diagnostic registers 1..7
// Assumes: frame decoder on CORE_CLK issues one-cycle rd/wr strobes; stage events are on CORE_CLK
`timescale 1ns/10ps
module driver_diag_config_regs (
	input  wire logic                      CORE_CLK,
	input  wire logic                      SYS_RST,
	input  wire diag_cfg_pkg::reg_req_s    REG_REQ,
	output logic [7:0]                     REG_RDATA,
	output logic                           REG_RVALID,
	input  wire diag_cfg_pkg::stage_evt_s  STAGE_EVT [1:diag_cfg_pkg::NUM_STAGES],
	input  wire diag_cfg_pkg::bridge_evt_s BRIDGE_EVT [1:2],
	input  wire logic                      WATCHDOG_ALARM_PIN,
	input  wire logic                      STEPPER_MODE_SEL,
	output logic [7:0]                     WATCHDOG_ANSWER_BYTE,
	output logic                           WATCHDOG_ANSWER_STROBE,
	output logic                           ALARM_RESET_ENABLE,
	output logic                           ALARM_CAN_DISABLE,
	output logic [5:0]                     ANSWER_WINDOW_LENGTH,
	output logic                           BRIDGE_MODE
);
	// ==========================================================
	// Decode helpers
	function automatic logic [4:0] stage_of(input int r, input int f);
		logic [4:0] s;
		s = 5'h00;
		unique case (r)
			1: s = 5'(1 + f);
			2: s = (f < 3) ? 5'(5 + f) : 5'h00;
			3: s = (f >= 2) ? 5'(11 + f) : 5'h00;
			4: s = 5'(15 + f);
			5: s = (f == 1) ? 5'h14 : 5'h00;
			6: s = 5'(21 + f);
			7: s = 5'(25 + f);
			default: s = 5'h00;
		endcase
		return s;
	endfunction : stage_of

	function automatic logic [1:0] stage_code(input logic [4:0] s, input diag_cfg_pkg::fault_kind_e k);
		logic bat_first;
		logic [1:0] c;
		bat_first = (s == 5'h15) || (s == 5'h17) || (s == 5'h19) || (s == 5'h1A);
		c = diag_cfg_pkg::FLD_OK;
		unique case (k)
			diag_cfg_pkg::KIND_SCG: c = bat_first ? diag_cfg_pkg::BF_SCG : diag_cfg_pkg::GF_SCG;
			diag_cfg_pkg::KIND_OL:  c = bat_first ? diag_cfg_pkg::BF_OL  : diag_cfg_pkg::GF_OL;
			diag_cfg_pkg::KIND_SCB: c = bat_first ? diag_cfg_pkg::BF_SCB : diag_cfg_pkg::GF_SCB;
			diag_cfg_pkg::KIND_NONE: c = diag_cfg_pkg::FLD_OK;
		endcase
		return c;
	endfunction : stage_code

	function automatic logic [7:0] bridge_code(input diag_cfg_pkg::bridge_kind_e k);
		logic [7:0] c;
		c = diag_cfg_pkg::HB_OK;
		unique case (k)
			diag_cfg_pkg::BK_SCG_OFF: c = diag_cfg_pkg::HB_SCG_OFF;
			diag_cfg_pkg::BK_SCB_OFF: c = diag_cfg_pkg::HB_SCB_OFF;
			diag_cfg_pkg::BK_OL_OFF:  c = diag_cfg_pkg::HB_OL_OFF;
			diag_cfg_pkg::BK_OL_ON:   c = diag_cfg_pkg::HB_OL_ON;
			diag_cfg_pkg::BK_OVC_ON:  c = diag_cfg_pkg::HB_OVC_ON;
			diag_cfg_pkg::BK_RUNNING: c = diag_cfg_pkg::HB_RUNNING;
			default:                  c = diag_cfg_pkg::HB_OK;
		endcase
		return c;
	endfunction : bridge_code

	function automatic logic [7:0] live_mask(input int r);
		logic [7:0] m;
		unique case (r)
			2: m = 8'h3F;
			3: m = 8'hF0;
			5: m = 8'h0C;
			default: m = 8'hFF;
		endcase
		return m;
	endfunction : live_mask

	// ==========================================================
	// State
	logic [7:0] diag_r     [1:7];
	logic [7:0] diag_nxt   [1:7];
	logic [7:0] wdctrl_r;
	logic       layout_r;
	logic       bridge_mode_r;
	logic       alarm_s1_r;
	logic       alarm_s2_r;
	logic       alarm_s3_r;
	logic       alarm_lvl_r;
	logic [7:0] rdata_nxt;
	logic [7:0] rd_sel_r;
	logic       diag_rd;
	logic       sub_ok;

	assign sub_ok  = (REG_REQ.sub_addr >= diag_cfg_pkg::SUB_FIRST) && (REG_REQ.sub_addr <= diag_cfg_pkg::SUB_LAST);
	assign diag_rd = REG_REQ.rd && (REG_REQ.main_addr == diag_cfg_pkg::MAIN_DIAG) && sub_ok;

	// ==========================================================
	// Alarm pin synchroniser, level taken when stages two and three agree
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			alarm_s1_r  <= 1'b0;
			alarm_s2_r  <= 1'b0;
			alarm_s3_r  <= 1'b0;
			alarm_lvl_r <= 1'b0;
		end else begin
			alarm_s1_r <= WATCHDOG_ALARM_PIN;
			alarm_s2_r <= alarm_s1_r;
			alarm_s3_r <= alarm_s2_r;
			if (alarm_s2_r == alarm_s3_r) begin
				alarm_lvl_r <= alarm_s3_r;
			end
		end
	end

	// ==========================================================
	// Diagnostic registers: latch faults, clear on read
	generate
		for (genvar r = 1; r <= 7; r++) begin : g_diag
			always_comb begin
				logic [4:0] s;
				logic       hb;
				s  = 5'h00;
				hb = (r >= 6) && bridge_mode_r;
				diag_nxt[r] = diag_r[r];
				if (diag_rd && (REG_REQ.sub_addr == 8'(r))) begin
					diag_nxt[r] = diag_cfg_pkg::DIAG_CLEAR & live_mask(r);
				end
				// set wins over clear; field encoding
				for (int f = 0; f < 4; f++) begin
					s = stage_of(r, f);
					if (!hb && (s != 5'h00) && STAGE_EVT[s].valid && (STAGE_EVT[s].kind != diag_cfg_pkg::KIND_NONE)) begin
						diag_nxt[r][2*f +: 2] = stage_code(s, STAGE_EVT[s].kind);
					end
				end
				if (hb && BRIDGE_EVT[(r >= 6) ? r - 5 : 1].valid
					&& (BRIDGE_EVT[(r >= 6) ? r - 5 : 1].kind != diag_cfg_pkg::BK_NONE)) begin
					diag_nxt[r] = bridge_code(BRIDGE_EVT[(r >= 6) ? r - 5 : 1].kind);
				end
			end

			always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					diag_r[r] <= diag_cfg_pkg::DIAG_RESET;
				end else begin
					diag_r[r] <= diag_nxt[r];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Read data mux with constant and live bits
	always_comb begin
		int idx;
		idx = int'(REG_REQ.sub_addr[2:0]);
		rdata_nxt = 8'h00;
		if (diag_rd) begin
			// unused pairs zero, reserved nibble ones
			rdata_nxt = diag_r[idx] & live_mask(idx);
			if (idx == 5) begin
				rdata_nxt = rdata_nxt | diag_cfg_pkg::REG5_ONES;
			end
			if (idx == 3) begin
				rdata_nxt = rdata_nxt | diag_cfg_pkg::REG3_ONES;
				rdata_nxt[diag_cfg_pkg::ALARM_BIT] = alarm_lvl_r;
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
			rd_sel_r   <= 8'h00;
		end else begin
			REG_RDATA  <= rdata_nxt;
			REG_RVALID <= REG_REQ.rd;
			rd_sel_r   <= diag_rd ? REG_REQ.sub_addr : 8'h00;
		end
	end

	// ==========================================================
	// Watchdog answer forwarding
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			WATCHDOG_ANSWER_BYTE   <= 8'h00;
			WATCHDOG_ANSWER_STROBE <= 1'b0;
		end else begin
			WATCHDOG_ANSWER_STROBE <= REG_REQ.wr && (REG_REQ.main_addr == diag_cfg_pkg::MAIN_ANSWER);
			if (REG_REQ.wr && (REG_REQ.main_addr == diag_cfg_pkg::MAIN_ANSWER)) begin
				WATCHDOG_ANSWER_BYTE <= REG_REQ.wdata;
			end
		end
	end

	// ==========================================================
	// Watchdog control register
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wdctrl_r <= diag_cfg_pkg::WDCTRL_RESET;
		end else if (REG_REQ.wr && (REG_REQ.main_addr == diag_cfg_pkg::MAIN_WDCTRL)) begin
			wdctrl_r <= REG_REQ.wdata;
		end
	end

	assign ALARM_RESET_ENABLE   = wdctrl_r[diag_cfg_pkg::WDC_RESET_BIT];
	assign ALARM_CAN_DISABLE    = wdctrl_r[diag_cfg_pkg::WDC_CANOFF_BIT];
	assign ANSWER_WINDOW_LENGTH = wdctrl_r[diag_cfg_pkg::WDC_WIN_MSB:0];

	// ==========================================================
	// Bridge layout register and effective mode
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			layout_r <= diag_cfg_pkg::LAYOUT_RESET;
		end else if (REG_REQ.wr && (REG_REQ.main_addr == diag_cfg_pkg::MAIN_LAYOUT) && !STEPPER_MODE_SEL) begin
			layout_r <= REG_REQ.wdata[diag_cfg_pkg::LAYOUT_BIT];
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			bridge_mode_r <= 1'b1;
		end else begin
			bridge_mode_r <= layout_r || STEPPER_MODE_SEL;
		end
	end

	assign BRIDGE_MODE = bridge_mode_r;

	// ==========================================================
	// Assertions
	AST_READ_CLEARS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(diag_rd && REG_REQ.sub_addr == 8'h04 && !STAGE_EVT[15].valid && !STAGE_EVT[16].valid
		 && !STAGE_EVT[17].valid && !STAGE_EVT[18].valid) |=> (diag_r[4] == 8'hFF))
		else $error("diagnostic register four not cleared by read");
	AST_REG5_ONES: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(REG_RVALID && rd_sel_r == 8'h05) |-> (REG_RDATA[7:4] == 4'hF))
		else $error("register five upper nibble not ones");
	AST_UNUSED_ZERO: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		REG_RVALID |-> ((rd_sel_r != 8'h02 || REG_RDATA[7:6] == 2'h0)
		&& ((rd_sel_r != 8'h03 && rd_sel_r != 8'h05) || REG_RDATA[1:0] == 2'h0)))
		else $error("unused pair not zero");
	AST_ALARM_LIVE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(REG_RVALID && rd_sel_r == 8'h03) |-> (REG_RDATA[3] == $past(alarm_lvl_r)))
		else $error("alarm level bit wrong");
	AST_GROUND_FIRST: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(STAGE_EVT[1].valid && STAGE_EVT[1].kind == diag_cfg_pkg::KIND_SCB) |=> (diag_r[1][1:0] == 2'h2))
		else $error("stage one battery short code wrong");
	AST_BATTERY_FIRST: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(!bridge_mode_r && STAGE_EVT[21].valid && STAGE_EVT[21].kind == diag_cfg_pkg::KIND_SCB)
		|=> (diag_r[6][1:0] == 2'h0))
		else $error("stage 21 battery short code wrong");
	AST_STAGE22: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(!bridge_mode_r && STAGE_EVT[22].valid && STAGE_EVT[22].kind == diag_cfg_pkg::KIND_SCG)
		|=> (diag_r[6][3:2] == 2'h0))
		else $error("stage 22 ground short code wrong");
	AST_STAGE25: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(!bridge_mode_r && STAGE_EVT[25].valid && STAGE_EVT[25].kind == diag_cfg_pkg::KIND_SCG)
		|=> (diag_r[7][1:0] == 2'h2))
		else $error("stage 25 ground short code wrong");
	AST_BRIDGE_OVC: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(bridge_mode_r && BRIDGE_EVT[1].valid && BRIDGE_EVT[1].kind == diag_cfg_pkg::BK_OVC_ON)
		|=> (diag_r[6] == 8'h03))
		else $error("bridge overcurrent code wrong");
	AST_BRIDGE_LEGAL: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(bridge_mode_r && $past(bridge_mode_r) && BRIDGE_EVT[1].valid) |=> (diag_r[6] inside
		{8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07, 8'hFF}))
		else $error("illegal bridge code");
	AST_SET_WINS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(diag_rd && REG_REQ.sub_addr == 8'h01 && STAGE_EVT[2].valid && STAGE_EVT[2].kind == diag_cfg_pkg::KIND_OL)
		|=> (diag_r[1][3:2] == 2'h1))
		else $error("fault lost during clearing read");
	AST_ANSWER_FWD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(REG_REQ.wr && REG_REQ.main_addr == diag_cfg_pkg::MAIN_ANSWER) |=> (WATCHDOG_ANSWER_STROBE
		&& WATCHDOG_ANSWER_BYTE == $past(REG_REQ.wdata)))
		else $error("answer byte not forwarded");
	AST_ANSWER_PULSE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		!(REG_REQ.wr && REG_REQ.main_addr == diag_cfg_pkg::MAIN_ANSWER) |=> !WATCHDOG_ANSWER_STROBE)
		else $error("answer strobe longer than one cycle");
	AST_WDCTRL: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(REG_REQ.wr && REG_REQ.main_addr == diag_cfg_pkg::MAIN_WDCTRL)
		|=> (ALARM_RESET_ENABLE == $past(REG_REQ.wdata[7])
		&& ALARM_CAN_DISABLE == $past(REG_REQ.wdata[6]) && ANSWER_WINDOW_LENGTH == $past(REG_REQ.wdata[5:0])))
		else $error("watchdog control not taken");
	AST_LAYOUT_LOCK: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		STEPPER_MODE_SEL |=> BRIDGE_MODE)
		else $error("half bridges while stepper mode selected");
	AST_LAYOUT_EFFECT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(!layout_r && !STEPPER_MODE_SEL) |=> !BRIDGE_MODE)
		else $error("half-bridge layout not applied");
	AST_UNMAPPED: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(REG_REQ.rd && REG_REQ.main_addr != diag_cfg_pkg::MAIN_DIAG) |=> (REG_RVALID && REG_RDATA == 8'h00))
		else $error("unmapped read returned data");
	AST_WINDOW_HOLD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		!(REG_REQ.wr && REG_REQ.main_addr == diag_cfg_pkg::MAIN_WDCTRL) |=> $stable(ANSWER_WINDOW_LENGTH))
		else $error("answer window changed without a write");
	AST_STEPPER_REFUSE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(REG_REQ.wr && REG_REQ.main_addr == diag_cfg_pkg::MAIN_LAYOUT && STEPPER_MODE_SEL)
		|=> $stable(layout_r))
		else $error("layout written while stepper mode selected");
	AST_BRIDGE_SCG: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(bridge_mode_r && BRIDGE_EVT[1].valid && BRIDGE_EVT[1].kind == diag_cfg_pkg::BK_SCG_OFF)
		|=> (diag_r[6] == 8'h01))
		else $error("bridge ground short code wrong");
	AST_SINGLE_NO_BRIDGE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(!bridge_mode_r && !diag_rd && BRIDGE_EVT[1].valid && !STAGE_EVT[21].valid && !STAGE_EVT[22].valid
		 && !STAGE_EVT[23].valid && !STAGE_EVT[24].valid) |=> $stable(diag_r[6]))
		else $error("bridge code written in single mode");
	AST_READ_ANSWERED: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		REG_REQ.rd |=> REG_RVALID)
		else $error("read not answered");

	// Cover points for the main scenarios
	COV_CLEAR_READ: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
		diag_rd ##1 REG_RVALID);
	COV_HALF_BRIDGE: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
		!BRIDGE_MODE ##1 STAGE_EVT[23].valid);
	COV_BRIDGE_FAULT: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
		bridge_mode_r && BRIDGE_EVT[2].valid);
	COV_ANSWER: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
		WATCHDOG_ANSWER_STROBE);
endmodule : driver_diag_config_regs

// ===== sim/host_model.sv
// Host model: issues register reads and writes on the request port
// Assumes: the bench calls its tasks; requests change at the falling edge
`timescale 1ns/10ps
module host_model (
	input  wire logic              clk,
	input  wire logic [7:0]        rdata,
	input  wire logic              rvalid,
	output diag_cfg_pkg::reg_req_s req
);
	// ==========================================
	// Idle request port
	initial begin
		req = '0;
	end

	// register write
	// One write strobe per call; released data is inverted
	task automatic wr(input logic [4:0] main, input logic [7:0] data);
		@(negedge clk);
		req = '{rd: 1'b0, wr: 1'b1, main_addr: main, sub_addr: 8'h00, wdata: data};
		@(negedge clk);
		req.wr = 1'b0;
		req.wdata = ~data;
		req.main_addr = ~main;
	endtask : wr

	// One read strobe; answer taken one cycle after the request
	task automatic rd(input logic [4:0] main, input logic [7:0] sub, output logic [7:0] data,
		output logic valid);
		@(negedge clk);
		req = '{rd: 1'b1, wr: 1'b0, main_addr: main, sub_addr: sub, wdata: 8'h00};
		@(negedge clk);
		req.rd = 1'b0;
		req.sub_addr = ~sub;
		data = rdata;
		valid = rvalid;
	endtask : rd
endmodule : host_model

// ===== sim/tb_top.sv
// Testbench: diagnostic and configuration register bank scenarios
// Assumes: host model drives requests; bench drives stage and bridge events
`timescale 1ns/10ps
module tb_top;
	localparam logic [4:0] DIAG = 5'h10;
	localparam logic [1:0] K_GND = 2'h1;
	localparam logic [1:0] K_OPEN = 2'h2;
	localparam logic [1:0] K_BAT = 2'h3;
	logic                      core_clk = 1'b0;
	logic                      sys_rst = 1'b1;
	diag_cfg_pkg::reg_req_s    req;
	logic [7:0]                rdata;
	logic                      rvalid;
	diag_cfg_pkg::stage_evt_s  stage_evt [1:diag_cfg_pkg::NUM_STAGES];
	diag_cfg_pkg::bridge_evt_s bridge_evt [1:2];
	logic                      alarm = 1'b0;
	logic                      stepper = 1'b1;
	logic [7:0]                ans_byte;
	logic                      ans_strobe;
	logic                      rst_en;
	logic                      can_dis;
	logic [5:0]                win_len;
	logic                      bridge_mode;
	int                        failures = 0;
	int                        n_tests = 0;
	int                        cycles = 0;
	logic [7:0]                codes [1:6] = '{8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07};

	// ==========================================
	// Clock, timeout and instances
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			stop_test();
		end
	end
	driver_diag_config_regs dut_u (
		.CORE_CLK(core_clk), .SYS_RST(sys_rst), .REG_REQ(req), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .STAGE_EVT(stage_evt), .BRIDGE_EVT(bridge_evt),
		.WATCHDOG_ALARM_PIN(alarm), .STEPPER_MODE_SEL(stepper),
		.WATCHDOG_ANSWER_BYTE(ans_byte), .WATCHDOG_ANSWER_STROBE(ans_strobe),
		.ALARM_RESET_ENABLE(rst_en), .ALARM_CAN_DISABLE(can_dis),
		.ANSWER_WINDOW_LENGTH(win_len), .BRIDGE_MODE(bridge_mode)
	);
	host_model host_u (.clk(core_clk), .rdata(rdata), .rvalid(rvalid), .req(req));

	// ==========================================
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [4:0] main, input logic [7:0] sub, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		host_u.rd(main, sub, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask : rdchk
	task automatic stage(input int s, input logic [1:0] k);
		@(negedge core_clk);
		stage_evt[s] = '{1'b1, diag_cfg_pkg::fault_kind_e'(k)};
		@(negedge core_clk);
		stage_evt[s].valid = 1'b0;
	endtask : stage
	task automatic bridge(input int b, input logic [2:0] k);
		@(negedge core_clk);
		bridge_evt[b] = '{1'b1, diag_cfg_pkg::bridge_kind_e'(k)};
		@(negedge core_clk);
		bridge_evt[b].valid = 1'b0;
	endtask : bridge
	task automatic stop_test();
		if (failures == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk({7'h00, bridge_mode}, 8'h01);
		chk({rst_en, can_dis, win_len}, 8'h00);
		rdchk(DIAG, 8'h01, 8'h00);
		rdchk(DIAG, 8'h01, 8'hFF);
	endtask : t_reset
	task automatic t_lowside();
		rdchk(DIAG, 8'h04, 8'h00);
		stage(16, K_OPEN);
		rdchk(DIAG, 8'h04, 8'hF7);
		rdchk(DIAG, 8'h02, 8'h00);
		rdchk(DIAG, 8'h03, 8'h04);
		rdchk(DIAG, 8'h05, 8'hF0);
		stage(1, K_GND);
		stage(2, K_OPEN);
		stage(3, K_BAT);
		rdchk(DIAG, 8'h01, 8'hE4);
		stage(7, K_BAT);
		rdchk(DIAG, 8'h02, 8'h2F);
		alarm = 1'b1;
		stage(14, K_OPEN);
		repeat (6) @(negedge core_clk);
		rdchk(DIAG, 8'h03, 8'h7C);
		alarm = 1'b0;
		repeat (6) @(negedge core_clk);
		rdchk(DIAG, 8'h03, 8'hF4);
		stage(20, K_GND);
		rdchk(DIAG, 8'h05, 8'hF0);
		fork
			rdchk(DIAG, 8'h01, 8'hFF);
			stage(2, K_OPEN);
		join
		rdchk(DIAG, 8'h01, 8'hF7);
		stage(1, K_BAT);
		rdchk(DIAG, 8'h01, 8'hFE);
	endtask : t_lowside
	task automatic t_single();
		host_u.wr(5'h12, 8'h00);
		repeat (3) @(negedge core_clk);
		chk({7'h00, bridge_mode}, 8'h01);
		stepper = 1'b0;
		host_u.wr(5'h12, 8'h00);
		repeat (3) @(negedge core_clk);
		chk({7'h00, bridge_mode}, 8'h00);
		rdchk(DIAG, 8'h06, 8'h00);
		rdchk(DIAG, 8'h07, 8'h00);
		stage(21, K_BAT);
		stage(22, K_GND);
		stage(23, K_GND);
		stage(24, K_OPEN);
		bridge(1, 3'h1);
		rdchk(DIAG, 8'h06, 8'h60);
		stage(25, K_GND);
		stage(27, K_GND);
		rdchk(DIAG, 8'h07, 8'hCE);
		stepper = 1'b1;
		repeat (3) @(negedge core_clk);
		chk({7'h00, bridge_mode}, 8'h01);
		stepper = 1'b0;
		repeat (3) @(negedge core_clk);
		chk({7'h00, bridge_mode}, 8'h00);
	endtask : t_single
	task automatic t_bridge();
		host_u.wr(5'h12, 8'h01);
		repeat (3) @(negedge core_clk);
		chk({7'h00, bridge_mode}, 8'h01);
		stage(21, K_BAT);
		rdchk(DIAG, 8'h06, 8'hFF);
		for (int i = 1; i <= 6; i++) begin
			bridge(1, 3'(i));
			rdchk(DIAG, 8'h06, codes[i]);
		end
		bridge(2, 3'h5);
		rdchk(DIAG, 8'h07, 8'h03);
		rdchk(DIAG, 8'h07, 8'hFF);
	endtask : t_bridge
	task automatic t_watchdog();
		host_u.wr(5'h0E, 8'hAB);
		chk({7'h00, ans_strobe}, 8'h01);
		chk(ans_byte, 8'hAB);
		@(negedge core_clk);
		chk({7'h00, ans_strobe}, 8'h00);
		host_u.wr(5'h11, 8'hC5);
		chk({rst_en, can_dis, win_len}, 8'hC5);
		host_u.wr(5'h11, 8'h3A);
		chk({rst_en, can_dis, win_len}, 8'h3A);
	endtask : t_watchdog
	task automatic t_unmapped();
		rdchk(DIAG, 8'h08, 8'h00);
		rdchk(DIAG, 8'h00, 8'h00);
		rdchk(5'h0E, 8'h01, 8'h00);
	endtask : t_unmapped

	// Reset, then the scenarios in order
	initial begin
		for (int s = 1; s <= diag_cfg_pkg::NUM_STAGES; s++) begin
			stage_evt[s] = '{1'b0, diag_cfg_pkg::KIND_NONE};
		end
		bridge_evt[1] = '{1'b0, diag_cfg_pkg::BK_NONE};
		bridge_evt[2] = '{1'b0, diag_cfg_pkg::BK_NONE};
		repeat (4) @(negedge core_clk);
		sys_rst = 1'b0;
		t_reset();
		t_lowside();
		t_single();
		t_bridge();
		t_watchdog();
		t_unmapped();
		stop_test();
	end
endmodule : tb_top
